//--- common/dhs_pkg.sv
// Purpose: shared constants for the high-speed two-wire write slave
// Assumes: lines sampled on i_mclk at 25 MHz
// Notes: bit positions refer to the control byte and the data word
package dhs_pkg;
	// ------------------------------------------------------------
	// byte framing
	// ------------------------------------------------------------
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [4:0] ADDR_PREFIX = 5'h13; // 1,0,0,1,1
	localparam logic [4:0] MCODE_PREFIX = 5'h01; // 0000 1xxx
	// ------------------------------------------------------------
	// control byte fields
	// ------------------------------------------------------------
	localparam int CTRL_LOAD_HI = 5;
	localparam int CTRL_LOAD_LO = 4;
	localparam int CTRL_BRCSEL = 2;
	localparam int CTRL_PD_FLAG = 0;
	// power-down mode bits in the upper data byte of the word
	localparam int PD_MODE_HI = 15;
	localparam int PD_MODE_LO = 13;
	// ------------------------------------------------------------
	// values after reset
	// ------------------------------------------------------------
	localparam logic [2:0] LINE_RST = 3'h6; // scl, sda high; select low
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [15:0] CODE_RST = 16'h0000;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [3:0] CNT_RST = 4'h0;
	// line vector bit positions
	localparam int LN_SCL = 2;
	localparam int LN_SDA = 1;
	localparam int LN_SEL = 0;
endpackage : dhs_pkg

//--- common/dhs_core_if.sv
// Purpose: carries line events and update requests between block parts
// Assumes: all signals on i_mclk
// Notes: events are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface dhs_core_if;
	logic scl_rise;
	logic scl_fall;
	logic scl_hi;
	logic sda;
	logic sel;
	logic start;
	logic stop;
	logic hs_mode;
	logic upd_stb;
	logic [7:0] ctrl_byte;
	logic [15:0] data_word;
	modport sync (output scl_rise, scl_fall, scl_hi, sda, sel, start, stop, input hs_mode);
	modport core (input scl_rise, scl_fall, scl_hi, sda, sel, start, stop,
		output hs_mode, upd_stb, ctrl_byte, data_word);
	modport upd (input upd_stb, ctrl_byte, data_word);
endinterface : dhs_core_if
`default_nettype wire

//--- rtl/dhs_line_sync.sv
// Purpose: synchronise and filter the bus lines, find edges and conditions
// Assumes: link clock well below i_mclk / 4
// Notes: filter needs two agreeing samples unless high-speed mode is on
`timescale 1ns/1ps
`default_nettype none
module dhs_line_sync
	import dhs_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic i_sel,
	dhs_core_if.sync lnk
);
	logic [2:0] s1_q, s1_d;
	logic [2:0] s2_q, s2_d;
	logic [2:0] s3_q, s3_d;
	logic [2:0] f_q, f_d;
	logic [2:0] p_q, p_d;

	// ------------------------------------------------------------
	// synchroniser and glitch filter
	// ------------------------------------------------------------
	// next values; only the second stage reads the first
	always_comb begin
		s1_d = {i_scl, i_sda, i_sel};
		s2_d = s1_q;
		s3_d = s2_q;
		p_d = f_q;
		// fast path in high-speed mode, else wait for agreement
		if (lnk.hs_mode || (s2_q == s3_q)) begin
			f_d = s2_q;
		end else begin
			f_d = f_q;
		end
	end

	// registers
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			s1_q <= LINE_RST;
			s2_q <= LINE_RST;
			s3_q <= LINE_RST;
			f_q <= LINE_RST;
			p_q <= LINE_RST;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
			f_q <= f_d;
			p_q <= p_d;
		end
	end

	// ------------------------------------------------------------
	// edges and conditions
	// ------------------------------------------------------------
	assign lnk.scl_rise = f_q[LN_SCL] & ~p_q[LN_SCL];
	assign lnk.scl_fall = ~f_q[LN_SCL] & p_q[LN_SCL];
	assign lnk.scl_hi = f_q[LN_SCL];
	assign lnk.sda = f_q[LN_SDA];
	assign lnk.sel = f_q[LN_SEL];
	assign lnk.start = f_q[LN_SCL] & p_q[LN_SCL] & p_q[LN_SDA] & ~f_q[LN_SDA];
	assign lnk.stop = f_q[LN_SCL] & p_q[LN_SCL] & ~p_q[LN_SDA] & f_q[LN_SDA];
endmodule : dhs_line_sync
`default_nettype wire

//--- rtl/dhs_update.sv
// Purpose: output register stage loaded at each conversion update
// Assumes: upd_stb one cycle, word and control stable with it
// Notes: outputs hold through stop conditions
`timescale 1ns/1ps
`default_nettype none
module dhs_update
	import dhs_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_n,
	dhs_core_if.upd lnk,
	output logic [15:0] o_code,
	output logic [1:0] o_load,
	output logic o_broadcast_sel,
	output logic o_powerdown_flag,
	output logic o_powerdown_mode_bit_a,
	output logic o_powerdown_mode_bit_b,
	output logic o_powerdown_mode_bit_c,
	output logic o_update
);
	logic [7:0] ctrl_q, ctrl_d;
	logic [15:0] code_q, code_d;
	logic upd_q, upd_d;
	logic [2:0] pdm_q, pdm_d;

	// next values: load on update only
	always_comb begin
		ctrl_d = ctrl_q;
		code_d = code_q;
		pdm_d = pdm_q;
		upd_d = lnk.upd_stb;
		if (lnk.upd_stb) begin
			ctrl_d = lnk.ctrl_byte;
			code_d = lnk.data_word;
			// mode bits only when the flag is set
			if (lnk.ctrl_byte[CTRL_PD_FLAG]) begin
				pdm_d = lnk.data_word[PD_MODE_HI:PD_MODE_LO];
			end else begin
				pdm_d = 3'h0;
			end
		end
	end

	// registers
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			ctrl_q <= CTRL_RST;
			code_q <= CODE_RST;
			upd_q <= 1'b0;
			pdm_q <= 3'h0;
		end else begin
			ctrl_q <= ctrl_d;
			code_q <= code_d;
			upd_q <= upd_d;
			pdm_q <= pdm_d;
		end
	end

	assign o_load = {ctrl_q[CTRL_LOAD_HI], ctrl_q[CTRL_LOAD_LO]};
	assign o_broadcast_sel = ctrl_q[CTRL_BRCSEL];
	assign o_powerdown_flag = ctrl_q[CTRL_PD_FLAG];
	assign o_code = code_q;
	assign o_update = upd_q;
	assign o_powerdown_mode_bit_a = pdm_q[2];
	assign o_powerdown_mode_bit_b = pdm_q[1];
	assign o_powerdown_mode_bit_c = pdm_q[0];
endmodule : dhs_update
`default_nettype wire

//--- rtl/dhs_write_slave.sv
// Purpose: two-wire write slave of a 16-bit converter, with high-speed mode
// Assumes: lines sampled on i_mclk; master keeps the protocol timing
// Notes: open-drain data pin as out/enable pair; read path not present
`timescale 1ns/1ps
`default_nettype none
module dhs_write_slave
	import dhs_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic i_address_select_pin,
	output logic o_sda_out,
	output logic o_sda_oe,
	output logic o_hs_mode,
	output logic [15:0] o_code,
	output logic [1:0] o_load,
	output logic o_broadcast_sel,
	output logic o_powerdown_flag,
	output logic o_powerdown_mode_bit_a,
	output logic o_powerdown_mode_bit_b,
	output logic o_powerdown_mode_bit_c,
	output logic o_update
);
	// ------------------------------------------------------------
	// types and state
	// ------------------------------------------------------------
	typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_NACK, ST_WAIT} dhs_state_t;
	typedef enum logic [1:0] {K_FIRST, K_CTRL, K_MSB, K_LSB} dhs_kind_t;

	dhs_core_if lnk ();

	dhs_state_t st_q, st_d;
	dhs_kind_t kind_q, kind_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] sh_q, sh_d;
	logic ack_hi_q, ack_hi_d;
	logic hs_q, hs_d;
	logic oe_q, oe_d;
	logic upd_q, upd_d;
	logic [7:0] ctrl_q, ctrl_d;
	logic [7:0] msb_q, msb_d;
	logic [7:0] lsb_q, lsb_d;
	logic byte_done;
	logic is_mcode;
	logic is_addr;

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	// own write address with select pin level
	function automatic logic addr_match(input logic [7:0] b, input logic sel);
		addr_match = (b == {ADDR_PREFIX, sel, 1'b0, 1'b0});
	endfunction

	function automatic dhs_kind_t next_kind(input dhs_kind_t k);
		case (k)
			K_FIRST: next_kind = K_CTRL;
			K_CTRL: next_kind = K_MSB;
			K_MSB: next_kind = K_LSB;
			// pairs repeat without a new control byte
			K_LSB: next_kind = K_MSB;
			default: next_kind = K_MSB;
		endcase
	endfunction

	assign byte_done = (st_q == ST_RX) && (cnt_q == BITS_PER_BYTE) && lnk.scl_fall;
	assign is_mcode = (sh_q[7:3] == MCODE_PREFIX);
	assign is_addr = addr_match(sh_q, lnk.sel);

	// ------------------------------------------------------------
	// protocol engine
	// ------------------------------------------------------------
	// next values of the byte engine
	always_comb begin
		st_d = st_q;
		kind_d = kind_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		ack_hi_d = ack_hi_q;
		hs_d = hs_q;
		oe_d = oe_q;
		upd_d = 1'b0;
		ctrl_d = ctrl_q;
		msb_d = msb_q;
		lsb_d = lsb_q;
		if (lnk.stop) begin
			hs_d = 1'b0;
			// back to idle; stored bytes kept
			st_d = ST_IDLE;
			oe_d = 1'b0;
			ack_hi_d = 1'b0;
		end else if (lnk.start) begin
			// start or repeated start opens a frame
			// repeated start loops back to addressing
			st_d = ST_RX;
			kind_d = K_FIRST;
			cnt_d = CNT_RST;
			oe_d = 1'b0;
			ack_hi_d = 1'b0;
		end else begin
			case (st_q)
				ST_IDLE: begin
					st_d = ST_IDLE;
				end
				ST_RX: begin
					if (lnk.scl_rise && (cnt_q != BITS_PER_BYTE)) begin
						sh_d = {sh_q[6:0], lnk.sda};
						cnt_d = cnt_q + 4'h1;
					end
					if (byte_done) begin
						ack_hi_d = 1'b0;
						case (kind_q)
							K_FIRST: begin
								if (is_mcode) begin
									// master code: no acknowledge, go fast
									hs_d = 1'b1;
									st_d = ST_NACK;
								end else if (is_addr) begin
									st_d = ST_ACK;
									oe_d = 1'b1;
								end else begin
									st_d = ST_WAIT;
								end
							end
							K_CTRL: begin
								ctrl_d = sh_q;
								st_d = ST_ACK;
								oe_d = 1'b1;
							end
							K_MSB: begin
								msb_d = sh_q;
								st_d = ST_ACK;
								oe_d = 1'b1;
							end
							K_LSB: begin
								lsb_d = sh_q;
								st_d = ST_ACK;
								oe_d = 1'b1;
							end
							default: st_d = ST_WAIT;
						endcase
					end
				end
				ST_ACK: begin
					// hold data low through ninth clock
					if (lnk.scl_rise) begin
						ack_hi_d = 1'b1;
					end
					if (lnk.scl_fall && ack_hi_q) begin
						oe_d = 1'b0;
						ack_hi_d = 1'b0;
						cnt_d = CNT_RST;
						st_d = ST_RX;
						kind_d = next_kind(kind_q);
						// update at falling edge of acknowledge
						upd_d = (kind_q == K_LSB);
					end
				end
				ST_NACK: begin
					// master repeats start after this clock
					if (lnk.scl_rise) begin
						ack_hi_d = 1'b1;
					end
					if (lnk.scl_fall && ack_hi_q) begin
						ack_hi_d = 1'b0;
						st_d = ST_WAIT;
					end
				end
				ST_WAIT: begin
					st_d = ST_WAIT;
				end
				default: begin
					st_d = ST_IDLE;
					oe_d = 1'b0;
				end
			endcase
		end
	end

	// reset lands in standard/fast mode, idle
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			st_q <= ST_IDLE;
			kind_q <= K_FIRST;
			cnt_q <= CNT_RST;
			sh_q <= BYTE_RST;
			ack_hi_q <= 1'b0;
			hs_q <= 1'b0;
			oe_q <= 1'b0;
			upd_q <= 1'b0;
			ctrl_q <= CTRL_RST;
			msb_q <= BYTE_RST;
			lsb_q <= BYTE_RST;
		end else begin
			st_q <= st_d;
			kind_q <= kind_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			ack_hi_q <= ack_hi_d;
			hs_q <= hs_d;
			oe_q <= oe_d;
			upd_q <= upd_d;
			ctrl_q <= ctrl_d;
			msb_q <= msb_d;
			lsb_q <= lsb_d;
		end
	end

	// ------------------------------------------------------------
	// connections
	// ------------------------------------------------------------
	assign lnk.hs_mode = hs_q;
	assign lnk.upd_stb = upd_q;
	assign lnk.ctrl_byte = ctrl_q;
	assign lnk.data_word = {msb_q, lsb_q};
	assign o_sda_out = 1'b0; // open drain, only pulls low
	assign o_sda_oe = oe_q;
	assign o_hs_mode = hs_q;

	dhs_line_sync u_sync (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_scl(i_scl),
		.i_sda(i_sda),
		.i_sel(i_address_select_pin),
		.lnk(lnk.sync)
	);

	dhs_update u_upd (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.lnk(lnk.upd),
		.o_code(o_code),
		.o_load(o_load),
		.o_broadcast_sel(o_broadcast_sel),
		.o_powerdown_flag(o_powerdown_flag),
		.o_powerdown_mode_bit_a(o_powerdown_mode_bit_a),
		.o_powerdown_mode_bit_b(o_powerdown_mode_bit_b),
		.o_powerdown_mode_bit_c(o_powerdown_mode_bit_c),
		.o_update(o_update)
	);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	stop_ends_hs_a: assert property (lnk.stop |=> !hs_q && st_q == ST_IDLE)
		else $error("stop did not leave high-speed mode");
	mcode_no_ack_a: assert property (byte_done && kind_q == K_FIRST && is_mcode
		|=> hs_q && !o_sda_oe ##1 !o_sda_oe)
		else $error("master code handled wrongly");
	addr_ack_a: assert property (byte_done && kind_q == K_FIRST && !is_mcode && is_addr
		|=> o_sda_oe && st_q == ST_ACK)
		else $error("own address not acknowledged");
	addr_miss_a: assert property (byte_done && kind_q == K_FIRST && !is_mcode && !is_addr
		|=> st_q == ST_WAIT && !o_sda_oe)
		else $error("foreign address acknowledged");
	ack_release_a: assert property (st_q == ST_ACK && lnk.scl_fall && ack_hi_q
		&& !lnk.start && !lnk.stop |=> !o_sda_oe && cnt_q == 4'h0)
		else $error("acknowledge not released at clock fall");
	upd_ack_fall_a: assert property (o_update |-> $past(upd_q) && $past(st_q, 2) == ST_ACK
		&& $past(kind_q, 2) == K_LSB)
		else $error("update not tied to lower-byte acknowledge");
	abort_no_upd_a: assert property ((lnk.start || lnk.stop) |=> !upd_q ##1 !o_update)
		else $error("update after aborted word");
	stop_keeps_a: assert property (lnk.stop |=> $stable(msb_q) && $stable(lsb_q)
		&& $stable(ctrl_q) ##1 $stable(o_code))
		else $error("stop changed stored state");
	msb_store_a: assert property (byte_done && kind_q == K_MSB && !lnk.start && !lnk.stop
		|=> msb_q == $past(sh_q) && kind_q == K_MSB)
		else $error("upper byte not stored");
	pair_loop_a: assert property (st_q == ST_ACK && kind_q == K_LSB && lnk.scl_fall
		&& ack_hi_q && !lnk.start && !lnk.stop |=> kind_q == K_MSB && upd_q)
		else $error("byte pair did not repeat");
endmodule : dhs_write_slave
`default_nettype wire

//--- testbench/dhs_master_model.sv
// Purpose: behavioural two-wire bus master for the write slave bench
// Assumes: steps on i_mclk edges; data line open drain with pull-up
// Notes: clock line rests high between frames; 320 ns bit period
`timescale 1ns/1ps
`default_nettype none
module dhs_master_model (
	input wire logic i_mclk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda
);
	// ------------------------------------------------------------
	// line phases
	// ------------------------------------------------------------
	localparam int HALF = 4; // half of the 320 ns bit period
	localparam int SLOW = 12; // low phase around the ack, lets it settle
	// lines idle high
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge i_mclk);
	endtask
	task automatic put_start();
		wait_clk(SLOW);
		o_sda <= 1'b1;
		wait_clk(HALF);
		o_scl <= 1'b1;
		wait_clk(HALF);
		o_sda <= 1'b0;
		wait_clk(HALF);
		o_scl <= 1'b0;
	endtask
	// stop, data rising while clock high
	task automatic put_stop();
		wait_clk(HALF);
		o_sda <= 1'b0;
		wait_clk(HALF);
		o_scl <= 1'b1;
		wait_clk(HALF);
		o_sda <= 1'b1;
		wait_clk(SLOW);
	endtask
	// data set in low phase, held over high phase
	task automatic put_bit(input logic b, input int low, output logic s);
		wait_clk(low / 2);
		o_sda <= b;
		wait_clk(low / 2);
		o_scl <= 1'b1;
		wait_clk(HALF);
		s = i_sda;
		o_scl <= 1'b0;
	endtask
	// msb first, ninth clock released for the answer
	task automatic put_byte(input logic [7:0] b, input int n, output logic ack_n);
		logic s;
		for (int i = 7; i > 7 - n; i--) begin
			put_bit(b[i], (i == 7) ? SLOW : HALF, s);
		end
		ack_n = 1'b1;
		if (n == 8) begin
			put_bit(1'b1, SLOW, ack_n);
		end
	endtask
endmodule // dhs_master_model
`default_nettype wire

//--- testbench/dhs_write_slave_test.sv
// Purpose: self-checking bench of the high-speed two-wire write slave
// Assumes: master model drives the lines, bench resolves the open drain
// Notes: table of plain writes first, then pairs, refusals and aborts
`timescale 1ns/1ps
`default_nettype none
module dhs_write_slave_test;
	import dhs_pkg::*;
	typedef struct packed {
		logic hs;
		logic sel;
		logic [7:0] mc;
		logic [7:0] ctrl;
		logic [15:0] word;
		logic [1:0] ld;
		logic [4:0] f;
	} dhs_row_t;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic sel = 1'b0;
	logic scl_m, sda_m, sda_w, sda_out, sda_oe, hs, upd, brc, pdf, pda, pdb, pdc;
	logic [15:0] code;
	logic [1:0] load;
	int miscompares = 0;
	int checked = 0;
	int upd_cnt = 0;
	int n;
	logic a;
	dhs_row_t r;
	// flags: broadcast, pd flag, pd mode a b c
	dhs_row_t rows [5] = '{
		'{1'b0, 1'b0, 8'h00, 8'h00, 16'h1234, 2'h0, 5'h00},
		'{1'b1, 1'b0, 8'h08, 8'h10, 16'habcd, 2'h1, 5'h00},
		'{1'b1, 1'b1, 8'h0f, 8'h24, 16'h00ff, 2'h2, 5'h10},
		'{1'b0, 1'b1, 8'h00, 8'h31, 16'ha000, 2'h3, 5'h0d},
		'{1'b1, 1'b0, 8'h0b, 8'h05, 16'he000, 2'h0, 5'h1f}};
	// ------------------------------------------------------------
	// clock, wire and parts
	// ------------------------------------------------------------
	always #20 mclk = ~mclk;
	assign sda_w = (sda_oe ? sda_out : 1'b1) & sda_m;
	always @(posedge mclk) if (upd === 1'b1) upd_cnt <= upd_cnt + 1;
	dhs_master_model M (.i_mclk(mclk), .i_sda(sda_w), .o_scl(scl_m), .o_sda(sda_m));
	dhs_write_slave DUT (.i_mclk(mclk), .i_rst_n(rst_n), .i_scl(scl_m), .i_sda(sda_w),
		.i_address_select_pin(sel), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
		.o_hs_mode(hs), .o_code(code), .o_load(load), .o_broadcast_sel(brc),
		.o_powerdown_flag(pdf), .o_powerdown_mode_bit_a(pda),
		.o_powerdown_mode_bit_b(pdb), .o_powerdown_mode_bit_c(pdc), .o_update(upd));
	// ------------------------------------------------------------
	// compare and transfer tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_out(input logic [15:0] w, input logic [1:0] ld, input logic [4:0] f,
		input int nu);
		chk("code", w, code);
		chk("load", 16'(ld), 16'(load));
		chk("flags", 16'(f), 16'({brc, pdf, pda, pdb, pdc}));
		chk("updates", 16'(nu), 16'(upd_cnt));
		chk("hs_off", 16'h0, 16'(hs));
	endtask
	task automatic head(input logic h, input logic [7:0] mc, input logic [7:0] ad,
		input logic ea);
		M.put_start();
		if (h) begin
			M.put_byte(mc, 8, a);
			chk("mcode_ack", 16'h1, 16'(a));
			chk("hs_on", 16'h1, 16'(hs));
			M.put_start();
		end
		M.put_byte(ad, 8, a);
		chk("addr_ack", 16'(ea), 16'(a));
	endtask
	task automatic send(input logic [7:0] b, input logic ea);
		M.put_byte(b, 8, a);
		chk("byte_ack", 16'(ea), 16'(a));
	endtask
	task automatic stop_test();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// watchdog well beyond the expected run
	initial begin
		#2000000;
		miscompares++;
		stop_test();
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (11) @(posedge mclk);
		@(negedge mclk);
		chk("rst_oe", 16'h0, 16'(sda_oe));
		chk_out(CODE_RST, 2'h0, 5'h00, 0);
		@(posedge mclk);
		rst_n <= 1'b1;
		repeat (8) @(posedge mclk);
		// table of single writes
		foreach (rows[k]) begin
			r = rows[k];
			sel <= r.sel;
			n = upd_cnt;
			head(r.hs, r.mc, {ADDR_PREFIX, r.sel, 2'b00}, 1'b0);
			send(r.ctrl, 1'b0);
			send(r.word[15:8], 1'b0);
			send(r.word[7:0], 1'b0);
			M.put_stop();
			chk_out(r.word, r.ld, r.f, n + 1);
		end
		// back to back pairs, then readdress on repeated start
		sel <= 1'b0;
		n = upd_cnt;
		head(1'b1, 8'h09, 8'h98, 1'b0);
		send(8'h20, 1'b0);
		send(8'h13, 1'b0);
		send(8'h57, 1'b0);
		send(8'h24, 1'b0);
		send(8'h68, 1'b0);
		// update lands a few cycles after the ninth clock falls
		repeat (8) @(posedge mclk);
		chk("pair_code", 16'h2468, code);
		chk("pair_upd", 16'(n + 2), 16'(upd_cnt));
		head(1'b0, 8'h00, 8'h98, 1'b0);
		send(8'h00, 1'b0);
		send(8'h0f, 1'b0);
		send(8'h0f, 1'b0);
		M.put_stop();
		chk_out(16'h0f0f, 2'h0, 5'h00, n + 3);
		// wrong select bit and read direction are refused
		for (int j = 0; j < 2; j++) begin
			head(1'b0, 8'h00, (j == 0) ? 8'h9c : 8'h99, 1'b1);
			send(8'h30, 1'b1);
			send(8'h55, 1'b1);
			send(8'h55, 1'b1);
			M.put_stop();
			chk_out(16'h0f0f, 2'h0, 5'h00, n + 3);
		end
		// lower byte cut short by start, then by stop
		for (int j = 0; j < 2; j++) begin
			head(1'b0, 8'h00, 8'h98, 1'b0);
			send(8'h30, 1'b0);
			send(8'h55, 1'b0);
			M.put_byte(8'haa, 4, a);
			if (j == 0) begin
				head(1'b0, 8'h00, 8'h98, 1'b0);
			end
			M.put_stop();
			chk_out(16'h0f0f, 2'h0, 5'h00, n + 3);
		end
		stop_test();
	end
endmodule // dhs_write_slave_test
`default_nettype wire
